// >>> sim/csspo_core_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module csspo_core_monitor
   import csspo_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire logic [9:0] i_avs_address,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic o_avs_waitrequest,
   input wire logic i_ext_irq,
   input wire logic o_stop_mode,
   input wire logic o_busy,
   input wire logic o_bank,
   input wire logic [7:0] o_flags,
   input wire logic [7:0] o_rp_low,
   input wire logic [7:0] o_rp_high
);
   // ==========================================================
   // command capture
   logic [7:0] src_r;
   wire logic tk;
   wire logic sub;
   wire logic [7:0] op;
   assign tk = i_avs_write && !o_avs_waitrequest && i_avs_address == CSSPO_A_CMD;
   assign op = i_avs_writedata[7:0];
   assign sub = (op[7:4] == CSSPO_OP_SUB_HI || op[7:4] == CSSPO_OP_SBC_HI)
      && op[3:0] >= CSSPO_OP_MODE_RR && op[3:0] <= CSSPO_OP_MODE_IM;
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         src_r <= 8'h00;
      end else if (i_avs_write && !o_avs_waitrequest && i_avs_address == CSSPO_A_SRC) begin
         src_r <= i_avs_writedata[7:0];
      end
   end
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_b);
   // ==========================================================
   // properties
   property p_sb0;
      tk && op == CSSPO_OP_SB0 |-> ##4 !o_bank && o_flags[7:1] == $past(o_flags[7:1], 4);
   endproperty
   a_sb0: assert property (p_sb0) else $error("bank zero select wrong");
   property p_sb1;
      tk && op == CSSPO_OP_SB1 |-> ##4 o_bank && o_flags[7:1] == $past(o_flags[7:1], 4);
   endproperty
   a_sb1: assert property (p_sb1) else $error("bank one select wrong");
   property p_scf;
      tk && op == CSSPO_OP_SCF |-> ##4 o_flags[7] && o_flags[6:0] == $past(o_flags[6:0], 4);
   endproperty
   a_scf: assert property (p_scf) else $error("carry force wrong");
   property p_sub_rr;
      tk && sub && op[3:0] == CSSPO_OP_MODE_RR |-> ##1 o_busy[*3] ##1 (!o_busy && o_flags[CSSPO_FLG_D]);
   endproperty
   a_sub_rr: assert property (p_sub_rr) else $error("short subtract timing");
   property p_sub_long;
      tk && sub && op[3:0] != CSSPO_OP_MODE_RR |-> ##1 o_busy[*5] ##1 (!o_busy && o_flags[CSSPO_FLG_D]);
   endproperty
   a_sub_long: assert property (p_sub_long) else $error("long subtract timing");
   property p_stop_in;
      tk && op == CSSPO_OP_STOP |-> ##1 (o_stop_mode && !o_busy);
   endproperty
   a_stop_in: assert property (p_stop_in) else $error("stop not entered");
   property p_stop_hold;
      o_stop_mode && !i_ext_irq && !$past(i_ext_irq) |=>
         o_stop_mode && $stable(o_flags) && $stable(o_rp_low) && $stable(o_rp_high);
   endproperty
   a_stop_hold: assert property (p_stop_hold) else $error("stop state lost");
   property p_srp_both;
      tk && op == CSSPO_OP_SRP && src_r[1:0] == 2'b00 |->
         ##4 o_rp_low[7:3] == {src_r[7:4], 1'b0} && o_rp_high[7:3] == {src_r[7:4], 1'b1};
   endproperty
   a_srp_both: assert property (p_srp_both) else $error("dual pointer load wrong");
   property p_srp_one;
      tk && op == CSSPO_OP_SRP && (src_r[1] ^ src_r[0]) |-> ##4 (src_r[1] ?
         (o_rp_low[7:3] == src_r[7:3] && o_rp_high == $past(o_rp_high, 4)) :
         (o_rp_high[7:3] == src_r[7:3] && o_rp_low == $past(o_rp_low, 4)));
   endproperty
   a_srp_one: assert property (p_srp_one) else $error("single pointer load wrong");
endmodule
`default_nettype wire

// >>> sim/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb
   import csspo_pkg::*;
;
   logic i_clk = 1'b0;
   logic i_rst_b = 1'b0;
   logic [9:0] av_a = 10'h000;
   logic av_r = 1'b0;
   logic av_w = 1'b0;
   logic [31:0] av_d = 32'h00000000;
   logic irq = 1'b0;
   logic [31:0] o_avs_readdata;
   logic o_avs_waitrequest, o_stop_mode, o_busy, o_bank;
   logic [7:0] o_flags, o_rp_low, o_rp_high;
   int fail_count = 0;
   int n_tests = 0;
   logic [31:0] g;
   logic [15:0] e;
   logic [7:0] i;
   logic [7:0] tv [5] = '{8'h03, 8'h90, 8'h65, 8'h21, 8'h0F};

   initial begin
      forever #12.5 i_clk = ~i_clk;
   end

   csspo_core DUT (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_avs_address(av_a), .i_avs_read(av_r),
      .i_avs_write(av_w), .i_avs_writedata(av_d), .o_avs_readdata(o_avs_readdata),
      .o_avs_waitrequest(o_avs_waitrequest), .i_ext_irq(irq), .o_stop_mode(o_stop_mode),
      .o_busy(o_busy), .o_bank(o_bank), .o_flags(o_flags), .o_rp_low(o_rp_low), .o_rp_high(o_rp_high));

   // ==========================================================
   // tasks
   task automatic finish_test;
      $display("comparisons=%0d mismatches=%0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic acc(input logic wr, input logic [9:0] a, input logic [7:0] d, output logic [31:0] q);
      av_a <= a;
      av_d <= {24'h000000, d};
      av_w <= wr;
      av_r <= !wr;
      // request held until waitrequest is seen low at a rising edge; read data taken there
      do @(posedge i_clk); while (o_avs_waitrequest !== 1'b0);
      q = o_avs_readdata;
      av_w <= 1'b0;
      av_r <= 1'b0;
      @(posedge i_clk);
   endtask

   // loads flags and operands, runs one opcode, checks result and flags
   task automatic xop(input logic [7:0] o, d, s, f, er, ef);
      logic [31:0] q;
      acc(1'b1, CSSPO_A_FLAGS, f, q);
      acc(1'b1, CSSPO_A_DST, d, q);
      acc(1'b1, CSSPO_A_SRC, s, q);
      acc(1'b1, CSSPO_A_CMD, o, q);
      do @(negedge i_clk); while (o_busy !== 1'b0);
      @(posedge i_clk);
      acc(1'b0, CSSPO_A_DST, 8'h00, q);
      chk(q, {24'h000000, er});
      acc(1'b0, CSSPO_A_FLAGS, 8'h00, q);
      chk(q, {24'h000000, ef});
   endtask

   // subtract reference: result, then flags C Z S V D H and kept low bits
   function automatic logic [15:0] sb(input logic [7:0] d, s, input logic ci, input logic [1:0] lo);
      logic [8:0] r;
      logic h;
      r = {1'b0, d} - {1'b0, s} - ci;
      h = ({1'b0, d[3:0]} < ({1'b0, s[3:0]} + ci));
      return {r[7:0], r[8], r[7:0] == 8'h00, r[7], (d[7] != s[7]) && (r[7] == s[7]), 1'b1, h, lo};
   endfunction

   // ==========================================================
   // sequence
   initial begin
      repeat (4) @(posedge i_clk);
      i_rst_b <= 1'b1;
      @(posedge i_clk);
      acc(1'b0, CSSPO_A_PTR_HIGH, 8'h00, g);
      chk(g, 32'h08);
      acc(1'b1, 10'h3F0, 8'h5A, g);
      acc(1'b0, 10'h3F0, 8'h00, g);
      chk(g, 32'h0);
      acc(1'b1, CSSPO_A_CMD, 8'h00, g);
      acc(1'b0, CSSPO_A_STATUS, 8'h00, g);
      chk(32'(g[3:0]), 32'h4);
      acc(1'b1, CSSPO_A_STATUS, 8'h04, g);
      acc(1'b0, CSSPO_A_STATUS, 8'h00, g);
      chk(32'(g[3:0]), 32'h0);
      xop(CSSPO_OP_RRC_R, 8'h55, 8'h00, 8'h0C, 8'h2A, 8'h8C);
      xop(CSSPO_OP_RRC_IR, 8'h17, 8'h00, 8'h80, 8'h8B, 8'hB0);
      xop(CSSPO_OP_SB0, 8'h33, 8'h00, 8'hFF, 8'h33, 8'hFE);
      chk(32'(o_bank), 32'h0);
      xop(CSSPO_OP_SB1, 8'h33, 8'h00, 8'h00, 8'h33, 8'h01);
      chk(32'(o_bank), 32'h1);
      xop(CSSPO_OP_SCF, 8'h33, 8'h00, 8'h06, 8'h33, 8'h86);
      chk(32'(o_flags), 32'h86);
      xop(CSSPO_OP_SCF, 8'h33, 8'h00, 8'h7F, 8'h33, 8'hFF);
      xop(CSSPO_OP_SRA_R, 8'h9A, 8'h00, 8'h9C, 8'hCD, 8'h2C);
      xop(CSSPO_OP_SRA_IR, 8'hBC, 8'h00, 8'h13, 8'hDE, 8'h23);
      xop(CSSPO_OP_SRA_R, 8'h01, 8'h00, 8'h00, 8'h00, 8'hC0);
      xop(CSSPO_OP_SWAP, 8'h3E, 8'h00, 8'h90, 8'hE3, 8'hB0);
      xop(CSSPO_OP_SWAP, 8'h00, 8'h00, 8'h00, 8'h00, 8'h40);
      xop(CSSPO_OP_SRP, 8'h33, 8'h40, 8'h00, 8'h33, 8'h00);
      chk(32'({o_rp_high, o_rp_low}), 32'h4840);
      xop(CSSPO_OP_SRP, 8'h33, 8'h52, 8'h00, 8'h33, 8'h00);
      chk(32'({o_rp_high, o_rp_low}), 32'h4850);
      xop(CSSPO_OP_SRP, 8'h33, 8'h69, 8'h00, 8'h33, 8'h00);
      acc(1'b0, CSSPO_A_PTR_LOW, 8'h00, g);
      chk(32'({o_rp_high, g[7:0]}), 32'h6850);
      xop(CSSPO_OP_SRP, 8'h33, 8'h9B, 8'h00, 8'h33, 8'h00);
      chk(32'({o_rp_high, o_rp_low}), 32'h6850);
      for (i = 0; i < 5; i++) begin
         e = sb(8'h21, tv[i], 1'b0, 2'b10);
         xop(8'h22 + i, 8'h21, tv[i], 8'h02, e[15:8], e[7:0]);
         acc(1'b0, CSSPO_A_STATUS, 8'h00, g);
         chk(32'(g[9:8]), (i < 2) ? 32'h2 : 32'h3);
         e = sb(8'h20, tv[i], 1'b1, 2'b01);
         xop(8'h32 + i, 8'h20, tv[i], 8'h81, e[15:8], e[7:0]);
      end
      acc(1'b1, CSSPO_A_CMD, CSSPO_OP_STOP, g);
      chk(32'(o_stop_mode), 32'h1);
      repeat (3) @(posedge i_clk);
      chk(32'(o_rp_high), 32'h68);
      irq <= 1'b1;
      @(posedge i_clk);
      irq <= 1'b0;
      repeat (2) @(negedge i_clk);
      chk(32'(o_stop_mode), 32'h0);
      @(posedge i_clk);
      for (i = 0; i < 3; i++) begin
         acc(1'b1, CSSPO_A_CMD, CSSPO_OP_IDLE, g);
      end
      acc(1'b0, CSSPO_A_STATUS, 8'h00, g);
      chk(32'(g[5:1]), 32'h0);
      acc(1'b1, CSSPO_A_CMD, CSSPO_OP_STOP, g);
      i_rst_b <= 1'b0;
      repeat (4) @(posedge i_clk);
      i_rst_b <= 1'b1;
      @(negedge i_clk);
      chk(32'({o_rp_high, 7'h00, o_stop_mode}), 32'h0800);
      @(posedge i_clk);
      finish_test;
   end

   initial begin
      repeat (20000) @(posedge i_clk);
      fail_count++;
      finish_test;
   end
endmodule

bind csspo_core csspo_core_monitor u_mon (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_avs_address(i_avs_address),
   .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata), .o_avs_waitrequest(o_avs_waitrequest),
   .i_ext_irq(i_ext_irq), .o_stop_mode(o_stop_mode), .o_busy(o_busy), .o_bank(o_bank),
   .o_flags(o_flags), .o_rp_low(o_rp_low), .o_rp_high(o_rp_high));
`default_nettype wire

// >>> verilog/csspo_alu.sv
`timescale 1ns/100ps
`default_nettype none
module csspo_alu
   import csspo_pkg::*;
(
   input wire logic [7:0] i_op,
   input wire logic [7:0] i_dst,
   input wire logic [7:0] i_src,
   input wire logic [7:0] i_flags,
   input wire logic [7:0] i_rpl,
   input wire logic [7:0] i_rph,
   output logic [7:0] o_res,
   output logic [7:0] o_flags,
   output logic [7:0] o_rpl,
   output logic [7:0] o_rph
);
   logic [8:0] diff;
   logic [4:0] low;
   logic cin;
   csspo_class_t cl;

   always_comb begin
      cl = csspo_class(i_op);
      o_res = i_dst;
      o_flags = i_flags;
      o_rpl = i_rpl;
      o_rph = i_rph;
      // subtract is an add of the complement; carry-in one, or not-carry for borrow
      cin = (cl == CL_SBC) ? ~i_flags[CSSPO_FLG_C] : 1'b1;
      diff = {1'b0, i_dst} + {1'b0, ~i_src} + {8'h00, cin};
      low = {1'b0, i_dst[3:0]} + {1'b0, ~i_src[3:0]} + {4'h0, cin};
      case (cl)
         CL_RRC: begin
            o_res = {i_flags[CSSPO_FLG_C], i_dst[7:1]};
            o_flags[CSSPO_FLG_C] = i_dst[0];
            o_flags[CSSPO_FLG_V] = i_dst[7] ^ i_flags[CSSPO_FLG_C];
         end
         CL_SB0: o_flags[CSSPO_FLG_BANK] = 1'b0;
         CL_SB1: o_flags[CSSPO_FLG_BANK] = 1'b1;
         CL_SUB, CL_SBC: begin
            o_res = diff[7:0];
            o_flags[CSSPO_FLG_C] = ~diff[8];
            o_flags[CSSPO_FLG_H] = ~low[4];
            o_flags[CSSPO_FLG_D] = 1'b1;
            o_flags[CSSPO_FLG_V] = (i_dst[7] != i_src[7]) && (diff[7] == i_src[7]);
         end
         CL_SCF: o_flags[CSSPO_FLG_C] = 1'b1;
         CL_SRA: begin
            o_res = {i_dst[7], i_dst[7:1]};
            o_flags[CSSPO_FLG_C] = i_dst[0];
            o_flags[CSSPO_FLG_V] = 1'b0;
         end
         CL_SRP: begin
            case (i_src[1:0])
               2'b10: o_rpl = {i_src[7:3], i_rpl[2:0]};
               2'b01: o_rph = {i_src[7:3], i_rph[2:0]};
               2'b00: begin
                  o_rpl = {i_src[7:4], 1'b0, i_rpl[2:0]};
                  o_rph = {i_src[7:4], 1'b1, i_rph[2:0]};
               end
               default: o_rpl = i_rpl;
            endcase
         end
         CL_SWAP: o_res = {i_dst[3:0], i_dst[7:4]};
         default: o_res = i_dst;
      endcase
      if (cl == CL_RRC || cl == CL_SUB || cl == CL_SBC || cl == CL_SRA || cl == CL_SWAP) begin
         o_flags[CSSPO_FLG_Z] = (o_res == 8'h00);
         o_flags[CSSPO_FLG_S] = o_res[7];
      end
   end
endmodule
`default_nettype wire

// >>> verilog/csspo_core.sv
// Decided for this implementation: the Avalon-MM slave port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module csspo_core
   import csspo_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst_b,
   // ==========================================================
   // avalon-mm slave
   input wire logic [9:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   // ==========================================================
   // wake and status
   input wire logic i_ext_irq,
   output logic o_stop_mode,
   output logic o_busy,
   output logic o_bank,
   output logic [7:0] o_flags,
   output logic [7:0] o_rp_low,
   output logic [7:0] o_rp_high
);
   // ==========================================================
   // state
   csspo_core_t s_r;
   csspo_core_t s_nxt;

   logic [7:0] alu_res;
   logic [7:0] alu_flags;
   logic [7:0] alu_rpl;
   logic [7:0] alu_rph;

   logic req;
   logic stall;
   logic take;
   logic wr_take;
   logic start;
   logic [7:0] wr_byte;
   csspo_class_t new_cl;

   // ==========================================================
   // datapath
   csspo_alu u_alu (
      .i_op(s_r.op),
      .i_dst(s_r.dst),
      .i_src(s_r.src),
      .i_flags(s_r.flags),
      .i_rpl(s_r.rpl),
      .i_rph(s_r.rph),
      .o_res(alu_res),
      .o_flags(alu_flags),
      .o_rpl(alu_rpl),
      .o_rph(alu_rph)
   );

   // ==========================================================
   // bus handshake
   assign req = i_avs_read | i_avs_write;
   // writes wait while an operation runs; everything waits in stop mode
   assign stall = (s_r.st == ST_STOP) | ((s_r.st == ST_EXEC) & i_avs_write);
   assign o_avs_waitrequest = req & ~s_r.ack;
   assign take = req & s_r.ack;
   assign wr_take = take & i_avs_write;
   assign wr_byte = i_avs_writedata[7:0];
   assign start = wr_take & (i_avs_address == CSSPO_A_CMD) & (s_r.st == ST_IDLE);
   assign new_cl = csspo_class(wr_byte);

   // ==========================================================
   // read mux
   function automatic logic [31:0] read_word(input logic [9:0] addr, input csspo_core_t s);
      logic [31:0] w;
      w = 32'h0000_0000;
      case (addr)
         CSSPO_A_CMD: w[7:0] = s.op;
         CSSPO_A_DST: w[7:0] = s.dst;
         CSSPO_A_SRC: w[7:0] = s.src;
         CSSPO_A_FLAGS: w[7:0] = s.flags;
         CSSPO_A_STATUS: begin
            w[CSSPO_ST_BUSY] = (s.st == ST_EXEC);
            w[CSSPO_ST_STOP] = (s.st == ST_STOP);
            w[CSSPO_ST_BADOP] = s.bad_op;
            w[CSSPO_ST_FILLERR] = s.fill_err;
            w[5:4] = s.fill_left;
            w[9:8] = s.bytes;
         end
         CSSPO_A_COUNT: w[15:0] = s.ops;
         CSSPO_A_PTR_LOW: w[7:0] = s.rpl;
         CSSPO_A_PTR_HIGH: w[7:0] = s.rph;
         default: w = 32'h0000_0000;
      endcase
      return w;
   endfunction

   // ==========================================================
   // next state
   always_comb begin
      s_nxt = s_r;
      s_nxt.ack = req & ~s_r.ack & ~stall;
      if (i_avs_read & ~s_r.ack & ~stall) begin
         s_nxt.rdata = read_word(i_avs_address, s_r);
      end

      // ----------------------------------------------------
      // plain register writes
      if (wr_take & (s_r.st == ST_IDLE)) begin
         case (i_avs_address)
            CSSPO_A_DST: s_nxt.dst = wr_byte;
            CSSPO_A_SRC: s_nxt.src = wr_byte;
            CSSPO_A_FLAGS: s_nxt.flags = wr_byte;
            CSSPO_A_PTR_LOW: s_nxt.rpl = wr_byte;
            CSSPO_A_PTR_HIGH: s_nxt.rph = wr_byte;
            CSSPO_A_STATUS: begin
               if (wr_byte[CSSPO_ST_BADOP]) s_nxt.bad_op = 1'b0;
               if (wr_byte[CSSPO_ST_FILLERR]) s_nxt.fill_err = 1'b0;
            end
            default: s_nxt.op = s_nxt.op;
         endcase
      end

      // ----------------------------------------------------
      // operation sequencing
      case (s_r.st)
         ST_IDLE: begin
            if (start) begin
               s_nxt.op = wr_byte;
               s_nxt.bytes = csspo_bytes(wr_byte);
               // the program owes idle fillers right after a release
               if (s_r.fill_left != 2'h0) begin
                  s_nxt.fill_left = s_r.fill_left - 2'h1;
                  if (new_cl != CL_IDLE) s_nxt.fill_err = 1'b1;
               end
               if (new_cl == CL_NONE) begin
                  s_nxt.bad_op = 1'b1;
               end else if (new_cl == CL_STOP) begin
                  s_nxt.st = ST_STOP;
                  s_nxt.ops = s_r.ops + 16'h0001;
               end else begin
                  s_nxt.st = ST_EXEC;
                  s_nxt.cnt = csspo_cycles(wr_byte) - 3'h1;
               end
            end
         end
         ST_EXEC: begin
            if (s_r.cnt == 3'h1) begin
               s_nxt.st = ST_IDLE;
               s_nxt.dst = alu_res;
               s_nxt.flags = alu_flags;
               s_nxt.rpl = alu_rpl;
               s_nxt.rph = alu_rph;
               s_nxt.ops = s_r.ops + 16'h0001;
               s_nxt.cnt = 3'h0;
            end else begin
               s_nxt.cnt = s_r.cnt - 3'h1;
            end
         end
         ST_STOP: begin
            // all registers hold; only an interrupt or reset wakes
            if (i_ext_irq) begin
               s_nxt.st = ST_IDLE;
               s_nxt.fill_left = CSSPO_FILL_NEED;
            end
         end
         default: s_nxt.st = ST_IDLE;
      endcase
   end

   // ==========================================================
   // registers
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         s_r.st <= ST_IDLE;
         s_r.op <= CSSPO_OP_IDLE;
         s_r.dst <= 8'h00;
         s_r.src <= 8'h00;
         s_r.flags <= CSSPO_FLAGS_RST;
         s_r.rpl <= CSSPO_PTR_LOW_RST;
         s_r.rph <= CSSPO_PTR_HIGH_RST;
         s_r.cnt <= 3'h0;
         s_r.bytes <= 2'h0;
         s_r.ack <= 1'b0;
         s_r.rdata <= 32'h0000_0000;
         s_r.bad_op <= 1'b0;
         s_r.fill_err <= 1'b0;
         s_r.fill_left <= 2'h0;
         s_r.ops <= 16'h0000;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ==========================================================
   // outputs
   assign o_avs_readdata = s_r.rdata;
   assign o_stop_mode = (s_r.st == ST_STOP);
   assign o_busy = (s_r.st == ST_EXEC);
   assign o_bank = s_r.flags[CSSPO_FLG_BANK];
   assign o_flags = s_r.flags;
   assign o_rp_low = s_r.rpl;
   assign o_rp_high = s_r.rph;
endmodule
`default_nettype wire

// >>> verilog/csspo_pkg.sv
`default_nettype none
package csspo_pkg;
   localparam logic [9:0] CSSPO_A_CMD = 10'h000;
   localparam logic [9:0] CSSPO_A_DST = 10'h004;
   localparam logic [9:0] CSSPO_A_SRC = 10'h008;
   localparam logic [9:0] CSSPO_A_FLAGS = 10'h00C;
   localparam logic [9:0] CSSPO_A_STATUS = 10'h010;
   localparam logic [9:0] CSSPO_A_COUNT = 10'h014;
   localparam logic [7:0] CSSPO_PTR_LOW_IDX = 8'hD6;
   localparam logic [7:0] CSSPO_PTR_HIGH_IDX = 8'hD7;
   localparam logic [9:0] CSSPO_A_PTR_LOW = {CSSPO_PTR_LOW_IDX, 2'b00};
   localparam logic [9:0] CSSPO_A_PTR_HIGH = {CSSPO_PTR_HIGH_IDX, 2'b00};

   localparam int CSSPO_FLG_C = 7;
   localparam int CSSPO_FLG_Z = 6;
   localparam int CSSPO_FLG_S = 5;
   localparam int CSSPO_FLG_V = 4;
   localparam int CSSPO_FLG_D = 3;
   localparam int CSSPO_FLG_H = 2;
   localparam int CSSPO_FLG_BANK = 0;

   localparam int CSSPO_ST_BUSY = 0;
   localparam int CSSPO_ST_STOP = 1;
   localparam int CSSPO_ST_BADOP = 2;
   localparam int CSSPO_ST_FILLERR = 3;

   localparam logic [7:0] CSSPO_FLAGS_RST = 8'h00;
   localparam logic [7:0] CSSPO_PTR_LOW_RST = 8'h00;
   localparam logic [7:0] CSSPO_PTR_HIGH_RST = 8'h08;
   localparam logic [1:0] CSSPO_FILL_NEED = 2'h3;

   localparam logic [7:0] CSSPO_OP_RRC_R = 8'hC0;
   localparam logic [7:0] CSSPO_OP_RRC_IR = 8'hC1;
   localparam logic [7:0] CSSPO_OP_SB0 = 8'h4F;
   localparam logic [7:0] CSSPO_OP_SB1 = 8'h5F;
   localparam logic [7:0] CSSPO_OP_SCF = 8'hDF;
   localparam logic [7:0] CSSPO_OP_SRA_R = 8'hD0;
   localparam logic [7:0] CSSPO_OP_SRA_IR = 8'hD1;
   localparam logic [7:0] CSSPO_OP_SRP = 8'h31;
   localparam logic [7:0] CSSPO_OP_STOP = 8'h7F;
   localparam logic [7:0] CSSPO_OP_SWAP = 8'hF0;
   localparam logic [7:0] CSSPO_OP_IDLE = 8'hFF;
   localparam logic [3:0] CSSPO_OP_SUB_HI = 4'h2;
   localparam logic [3:0] CSSPO_OP_SBC_HI = 4'h3;
   localparam logic [3:0] CSSPO_OP_MODE_RR = 4'h2;
   localparam logic [3:0] CSSPO_OP_MODE_IM = 4'h6;
   localparam logic [3:0] CSSPO_OP_MODE_RIR = 4'h3;

   localparam logic [2:0] CSSPO_CYC_SHORT = 3'h4;
   localparam logic [2:0] CSSPO_CYC_LONG = 3'h6;
   localparam logic [1:0] CSSPO_BYTES_ONE = 2'h1;
   localparam logic [1:0] CSSPO_BYTES_TWO = 2'h2;
   localparam logic [1:0] CSSPO_BYTES_THREE = 2'h3;

   typedef enum logic [3:0] {
      CL_NONE, CL_RRC, CL_SB0, CL_SB1, CL_SUB, CL_SBC, CL_SCF,
      CL_SRA, CL_SRP, CL_STOP, CL_SWAP, CL_IDLE
   } csspo_class_t;

   typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_STOP} csspo_state_t;

   typedef struct packed {
      csspo_state_t st;
      logic [7:0] op;
      logic [7:0] dst;
      logic [7:0] src;
      logic [7:0] flags;
      logic [7:0] rpl;
      logic [7:0] rph;
      logic [2:0] cnt;
      logic [1:0] bytes;
      logic ack;
      logic [31:0] rdata;
      logic bad_op;
      logic fill_err;
      logic [1:0] fill_left;
      logic [15:0] ops;
   } csspo_core_t;

   function automatic csspo_class_t csspo_class(input logic [7:0] op);
      csspo_class_t c;
      c = CL_NONE;
      if (op[3:0] >= CSSPO_OP_MODE_RR && op[3:0] <= CSSPO_OP_MODE_IM) begin
         if (op[7:4] == CSSPO_OP_SUB_HI) c = CL_SUB;
         if (op[7:4] == CSSPO_OP_SBC_HI) c = CL_SBC;
      end
      case (op)
         CSSPO_OP_RRC_R, CSSPO_OP_RRC_IR: c = CL_RRC;
         CSSPO_OP_SB0: c = CL_SB0;
         CSSPO_OP_SB1: c = CL_SB1;
         CSSPO_OP_SCF: c = CL_SCF;
         CSSPO_OP_SRA_R, CSSPO_OP_SRA_IR: c = CL_SRA;
         CSSPO_OP_SRP: c = CL_SRP;
         CSSPO_OP_STOP: c = CL_STOP;
         CSSPO_OP_SWAP: c = CL_SWAP;
         CSSPO_OP_IDLE: c = CL_IDLE;
         default: c = c;
      endcase
      return c;
   endfunction

   function automatic logic [2:0] csspo_cycles(input logic [7:0] op);
      csspo_class_t c;
      c = csspo_class(op);
      if ((c == CL_SUB || c == CL_SBC) && op[3:0] != CSSPO_OP_MODE_RR) begin
         return CSSPO_CYC_LONG;
      end
      return CSSPO_CYC_SHORT;
   endfunction

   function automatic logic [1:0] csspo_bytes(input logic [7:0] op);
      csspo_class_t c;
      c = csspo_class(op);
      case (c)
         CL_SUB, CL_SBC: begin
            // both working-register forms fit in two bytes
            if (op[3:0] == CSSPO_OP_MODE_RR || op[3:0] == CSSPO_OP_MODE_RIR) return CSSPO_BYTES_TWO;
            return CSSPO_BYTES_THREE;
         end
         CL_SB0, CL_SB1, CL_SCF, CL_STOP, CL_IDLE: return CSSPO_BYTES_ONE;
         default: return CSSPO_BYTES_TWO;
      endcase
   endfunction
endpackage
`default_nettype wire
